// ---- dv/clprg_far_model.sv ----
// Peripheral trigger and watchdog model facing the request gate
`timescale 1ns/1ps
module clprg_far_model (
	input wire logic clk_i,
	input wire clprg_pkg::clprg_srn_vec_t fire_i,
	input wire clprg_pkg::clprg_cpu_vec_t wdt_i,
	output clprg_pkg::clprg_srn_vec_t trig_o,
	output clprg_pkg::clprg_cpu_vec_t wdt_o
);
	import clprg_pkg::*;
	initial begin
		trig_o = '0;
		wdt_o = '0;
	end
	// Trigger only as long as asked, then quiet as if its clock were gated
	always @(posedge clk_i) begin
		trig_o <= fire_i;
		wdt_o <= wdt_i;
	end
endmodule

// ---- dv/clprg_tb_top.sv ----
// Self-checking bench for the CPU low-power request gate
`timescale 1ns/1ps
module clprg_tb_top;
	import clprg_pkg::*;
	logic clk_i, rst_i, cyc, stb, we, ack, irq, ssl, sst;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, dat_o;
	clprg_adr_t adr;
	clprg_cpu_vec_t idle, wdt_req, wdt;
	clprg_srn_vec_t fire, trig;
	int fail_count, checked;
	clprg_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_we_i(we),
		.wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.periph_trig_i(trig), .wdt_bit15_i(wdt), .irq_o(irq), .cpu_idle_o(idle),
		.sys_sleep_o(ssl), .sys_standby_o(sst));
	clprg_far_model u_far (.clk_i(clk_i), .fire_i(fire), .wdt_i(wdt_req), .trig_o(trig),
		.wdt_o(wdt));
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wb(input clprg_adr_t a, input logic w, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		@(posedge clk_i);
		while (ack !== 1'b1) @(posedge clk_i);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task rd(input string what, input clprg_adr_t a, input logic [31:0] e);
		wb(a, 1'b0, 32'h0);
		cmp(what, e, rdat);
	endtask
	task cyc_n(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task t_idle();
		@(posedge clk_i);
		fire <= 8'h80;
		@(posedge clk_i);
		fire <= 8'h00;
		cyc_n(2);
		wb(8'h00, 1'b1, 32'h1);
		cyc_n(2);
		cmp("idle early", 32'h0, {30'h0, idle});
		cyc_n(1);
		cmp("idle entered", 32'h1, {30'h0, idle});
		rd("pmc0", 8'h00, 32'h1);
	endtask
	task t_wdt_irq();
		@(posedge clk_i);
		wdt_req <= 2'b01;
		cyc_n(5);
		cmp("idle after wdt", 32'h0, {30'h0, idle});
		rd("pmc0 cleared", 8'h00, 32'h0);
		rd("istat wake", 8'h30, 32'h1);
		wdt_req <= 2'b00;
		wb(8'h34, 1'b1, 32'h1F);
		cyc_n(2);
		cmp("irq on", 32'h1, {31'h0, irq});
		wb(8'h34, 1'b1, 32'h0);
		cyc_n(2);
		cmp("irq masked", 32'h0, {31'h0, irq});
		wb(8'h34, 1'b1, 32'h1F);
		wb(8'h30, 1'b1, 32'h1F);
		cyc_n(2);
		cmp("irq cleared", 32'h0, {31'h0, irq});
		rd("unmapped", 8'h3C, 32'h0);
	endtask
	task t_refuse();
		wb(8'h40, 1'b1, 32'h02);
		@(posedge clk_i);
		fire <= 8'h01;
		@(posedge clk_i);
		fire <= 8'h00;
		cyc_n(3);
		rd("node0", 8'h40, 32'h6);
		rd("winner0", 8'h20, 32'h100);
		wb(8'h00, 1'b1, 32'h1);
		cyc_n(6);
		rd("pmc0 refused", 8'h00, 32'h0);
		rd("istat refused", 8'h30, 32'h4);
		cmp("still running", 32'h0, {30'h0, idle});
	endtask
	task t_wake_race();
		wb(8'h40, 1'b1, 32'h0A);
		cyc_n(2);
		wb(8'h00, 1'b1, 32'h1);
		cyc_n(6);
		cmp("idle again", 32'h1, {30'h0, idle});
		wb(8'h40, 1'b1, 32'h12);
		cyc_n(4);
		cmp("woken by node", 32'h0, {30'h0, idle});
		rd("pmc0 woken", 8'h00, 32'h0);
		wb(8'h40, 1'b1, 32'h0A);
		cyc_n(1);
		@(posedge clk_i);
		fire <= 8'h01;
		wb(8'h00, 1'b1, 32'h1);
		fire <= 8'h00;
		cyc_n(6);
		cmp("same moment", 32'h0, {30'h0, idle});
		rd("pmc0 race", 8'h00, 32'h0);
		wb(8'h40, 1'b1, 32'h08);
	endtask
	task t_sys();
		wb(8'h04, 1'b1, 32'h1);
		cyc_n(6);
		wb(8'h00, 1'b1, 32'h2);
		cyc_n(6);
		cmp("sys sleep", 32'h1, {31'h0, ssl});
		rd("mode", 8'h10, 32'h13);
		@(posedge clk_i);
		wdt_req <= 2'b10;
		cyc_n(5);
		cmp("sleep left", 32'h0, {31'h0, ssl});
		cmp("cpu1 woke", 32'h1, {30'h0, idle});
		@(posedge clk_i);
		wdt_req <= 2'b00;
	endtask
	task t_standby();
		wb(8'h04, 1'b1, 32'h3);
		cyc_n(6);
		cmp("sys standby", 32'h1, {31'h0, sst});
		cmp("no sleep", 32'h0, {31'h0, ssl});
		wb(8'h44, 1'b1, 32'h13);
		cyc_n(4);
		cmp("standby left", 32'h0, {31'h0, sst});
		cmp("cpu0 kept idle", 32'h1, {30'h0, idle});
		rd("winner1", 8'h24, 32'h101);
		rd("istat all", 8'h30, 32'h17);
	endtask
	task report_and_stop();
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#100us;
		fail_count++;
		report_and_stop();
	end
	initial begin
		{rst_i, cyc, stb, we, sel, adr, wdat, fire, wdt_req} = '0;
		rst_i = 1'b1;
		fail_count = 0;
		checked = 0;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		t_idle();
		t_wdt_irq();
		t_refuse();
		t_wake_race();
		t_sys();
		t_standby();
		report_and_stop();
	end
endmodule

// ---- dv/clprg_top_properties.sv ----
// Port-level assertions for the CPU low-power request gate
`timescale 1ns/1ps
module clprg_top_properties (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire clprg_pkg::clprg_adr_t wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire clprg_pkg::clprg_srn_vec_t periph_trig_i,
	input wire clprg_pkg::clprg_cpu_vec_t wdt_bit15_i,
	input wire logic irq_o,
	input wire clprg_pkg::clprg_cpu_vec_t cpu_idle_o,
	input wire logic sys_sleep_o,
	input wire logic sys_standby_o
);
	import clprg_pkg::*;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ==========================================================
	// Bus handshake
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	chk_ack_once: assert property (s_req |=> s_pulse)
		else $error("ack is not a single pulse");
	chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	// ==========================================================
	// Power modes
	chk_sleep_idle: assert property (sys_sleep_o |-> &cpu_idle_o)
		else $error("sleep without all cpus idle");
	chk_stby_idle: assert property (sys_standby_o |-> &cpu_idle_o)
		else $error("standby without all cpus idle");
	chk_wake_sys: assert property ($fell(cpu_idle_o[0]) || $fell(cpu_idle_o[1]) |->
		!sys_sleep_o && !sys_standby_o) else $error("system mode kept after wake");
	chk_wdt_wake: assert property (cpu_idle_o[0] && wdt_bit15_i[0] &&
		!$past(wdt_bit15_i[0]) |-> ##[1:2] !cpu_idle_o[0]) else $error("no watchdog wake");
	chk_apply_delay: assert property ($rose(cpu_idle_o[0]) |-> $past(wb_cyc_i && wb_stb_i
		&& !wb_ack_o && wb_we_i && wb_adr_i == 8'h00, 5)) else $error("idle not 4 cycles after request");
	chk_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !irq_o && !sys_sleep_o
		&& !sys_standby_o && cpu_idle_o == 2'b00) else $error("outputs set after reset");
endmodule
bind clprg_top clprg_top_properties u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
	.wb_dat_i(wb_dat_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.periph_trig_i(periph_trig_i), .wdt_bit15_i(wdt_bit15_i), .irq_o(irq_o),
	.cpu_idle_o(cpu_idle_o), .sys_sleep_o(sys_sleep_o), .sys_standby_o(sys_standby_o));

// ---- rtl/clprg_defs.svh ----
// Constants of the CPU low-power request gate: sizes, offsets, fields, timing
`ifndef CLPRG_DEFS_SVH
`define CLPRG_DEFS_SVH

// ==========================================================================
// Sizes
`define CLPRG_NCPU 2
`define CLPRG_NSRN 8
`define CLPRG_IDX_W 3

// ==========================================================================
// Register byte offsets
`define CLPRG_OFS_PMC0 8'h00
`define CLPRG_OFS_MODE 8'h10
`define CLPRG_OFS_LWR0 8'h20
`define CLPRG_OFS_ISTAT 8'h30
`define CLPRG_OFS_IMASK 8'h34
`define CLPRG_OFS_SRN_BASE 8'h40
`define CLPRG_SRN_SPAN 3'h2

// ==========================================================================
// Service request node fields
`define CLPRG_SRN_TOS_BIT 0
`define CLPRG_SRN_SRE_BIT 1
`define CLPRG_SRN_SRR_BIT 2
`define CLPRG_SRN_CLR_BIT 3
`define CLPRG_SRN_SET_BIT 4

// ==========================================================================
// Mode, winner and interrupt status fields
`define CLPRG_MODE_SLEEP_BIT 4
`define CLPRG_MODE_STBY_BIT 5
`define CLPRG_LWR_VLD_BIT 8
`define CLPRG_EV_WAKE_LSB 0
`define CLPRG_EV_REF_LSB 2
`define CLPRG_EV_SYS_BIT 4
`define CLPRG_EV_W 5

// ==========================================================================
// Reset values and timing
`define CLPRG_RST_MASK 5'h00
`define CLPRG_APPLY_RELOAD 3'h3

`endif

// ---- rtl/clprg_pkg.sv ----
// Types shared by the CPU low-power request gate modules
`include "clprg_defs.svh"
package clprg_pkg;
	typedef logic [7:0] clprg_adr_t;
	typedef logic [`CLPRG_NCPU-1:0] clprg_cpu_vec_t;
	typedef logic [`CLPRG_NSRN-1:0] clprg_srn_vec_t;
	typedef logic [`CLPRG_IDX_W-1:0] clprg_idx_t;
	typedef logic [`CLPRG_NCPU-1:0][`CLPRG_IDX_W-1:0] clprg_win_t;
	typedef logic [4:0] clprg_srn_wdat_t;
	typedef logic [`CLPRG_EV_W-1:0] clprg_ev_t;

	typedef enum logic [1:0] {
		CLPRG_REQ_RUN = 2'b00,
		CLPRG_REQ_IDLE = 2'b01,
		CLPRG_REQ_SLEEP = 2'b10,
		CLPRG_REQ_STANDBY = 2'b11
	} clprg_req_t;

	typedef enum logic [1:0] {
		CLPRG_CS_RUN = 2'b00,
		CLPRG_CS_APPLY = 2'b01,
		CLPRG_CS_IDLE = 2'b10
	} clprg_cpu_st_t;

	typedef struct packed {
		clprg_srn_vec_t target_cpu_select;
		clprg_srn_vec_t request_enable_bit;
		clprg_srn_vec_t request_pending_flag;
		clprg_cpu_vec_t pend;
		clprg_win_t win;
		clprg_cpu_vec_t win_vld;
	} clprg_bank_st_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic irq;
		clprg_req_t [`CLPRG_NCPU-1:0] req;
		clprg_cpu_st_t [`CLPRG_NCPU-1:0] st;
		logic [`CLPRG_NCPU-1:0][2:0] cnt;
		clprg_cpu_vec_t wdt_prev;
		clprg_ev_t stat;
		clprg_ev_t mask;
		clprg_cpu_vec_t idle;
		logic sys_sleep;
		logic sys_standby;
	} clprg_top_st_t;
endpackage

// ---- rtl/clprg_srn_bank.sv ----
// Service request nodes with registered per-CPU pending and winner outputs
`timescale 1ns/1ps
module clprg_srn_bank (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire clprg_pkg::clprg_srn_vec_t trig_i,
	input wire logic wr_i,
	input wire clprg_pkg::clprg_idx_t wr_idx_i,
	input wire clprg_pkg::clprg_srn_wdat_t wr_dat_i,
	output clprg_pkg::clprg_srn_vec_t tos_o,
	output clprg_pkg::clprg_srn_vec_t sre_o,
	output clprg_pkg::clprg_srn_vec_t srr_o,
	output clprg_pkg::clprg_cpu_vec_t pend_o,
	output clprg_pkg::clprg_win_t win_o,
	output clprg_pkg::clprg_cpu_vec_t win_vld_o
);
	import clprg_pkg::*;

	clprg_bank_st_t s, n;

	// ======================================================================
	// Pending test, ignoring priority and CPU acceptance
	function automatic logic pend_for(input logic target_cpu_select, input logic request_enable_bit, input logic request_pending_flag,
			input int cpu);
		return request_pending_flag && request_enable_bit && (int'(target_cpu_select) == cpu);
	endfunction

	always_comb begin
		n = s;
		for (int i = 0; i < `CLPRG_NSRN; i++) begin
			if (wr_i && wr_idx_i == `CLPRG_IDX_W'(i)) begin
				n.target_cpu_select[i] = wr_dat_i[`CLPRG_SRN_TOS_BIT];
				n.request_enable_bit[i] = wr_dat_i[`CLPRG_SRN_SRE_BIT];
				if (wr_dat_i[`CLPRG_SRN_CLR_BIT]) begin
					n.request_pending_flag[i] = 1'b0;
				end
			end
			// Set wins over clear; flag holds after the trigger is gone
			if (trig_i[i] || (wr_i && wr_idx_i == `CLPRG_IDX_W'(i)
					&& wr_dat_i[`CLPRG_SRN_SET_BIT])) begin
				n.request_pending_flag[i] = 1'b1;
			end
		end
		for (int c = 0; c < `CLPRG_NCPU; c++) begin
			n.pend[c] = 1'b0;
			n.win_vld[c] = 1'b0;
			n.win[c] = '0;
			// Lowest numbered node wins; scan downward so it is written last
			for (int i = `CLPRG_NSRN - 1; i >= 0; i--) begin
				if (pend_for(s.target_cpu_select[i], s.request_enable_bit[i], s.request_pending_flag[i], c)) begin
					n.pend[c] = 1'b1;
					n.win_vld[c] = 1'b1;
					n.win[c] = `CLPRG_IDX_W'(i);
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tos_o = s.target_cpu_select;
	assign sre_o = s.request_enable_bit;
	assign srr_o = s.request_pending_flag;
	assign pend_o = s.pend;
	assign win_o = s.win;
	assign win_vld_o = s.win_vld;
endmodule

// ---- rtl/clprg_top.sv ----
// CPU low-power request gate: idle/sleep/standby entry and wake-up logic
// Functional notes
// - No idle entry while CPU interrupt pending
// - Idle holds until wake event, pending included
// - Pending means target match, enable, flag set
// - Flag set by trigger or set-request write
// - Latched enabled request stays pending after trigger
// - Pending check ignores priority and CPU enable
// - Interrupt before or with request blocks entry
// - Interrupt, or watchdog bit rise once idle, clears field
// - Request write during pending is discarded
// - System low power only when all CPUs idle
// - Mode applies several cycles after accepted write
`timescale 1ns/1ps
module clprg_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire clprg_pkg::clprg_adr_t wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire clprg_pkg::clprg_srn_vec_t periph_trig_i,
	input wire clprg_pkg::clprg_cpu_vec_t wdt_bit15_i,
	output logic irq_o,
	output clprg_pkg::clprg_cpu_vec_t cpu_idle_o,
	output logic sys_sleep_o,
	output logic sys_standby_o
);
	import clprg_pkg::*;

	clprg_top_st_t s, n;
	clprg_srn_vec_t target_cpu_select, request_enable_bit, request_pending_flag;
	clprg_cpu_vec_t pend, win_vld;
	clprg_win_t win;
	clprg_ev_t ev;
	logic acc;
	logic wr;
	logic srn_hit;
	logic all_idle;
	logic sleep_req;
	logic stby_req;
	logic [31:0] rd;

	// ======================================================================
	// Address decode helpers
	function automatic logic hit_cpu(input clprg_adr_t a, input clprg_adr_t base, input int c);
		return a == 8'(base + 8'(4 * c));
	endfunction

	function automatic logic is_low_req(input clprg_req_t r);
		return r == CLPRG_REQ_SLEEP || r == CLPRG_REQ_STANDBY;
	endfunction

	// ======================================================================
	// Bus qualifiers; ack rises one cycle after the strobe and drops next
	assign acc = wb_cyc_i & wb_stb_i & ~s.ack;
	assign wr = acc & wb_we_i & wb_sel_i[0];
	assign srn_hit = wb_adr_i[7:5] == `CLPRG_SRN_SPAN;

	clprg_srn_bank u_bank (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.trig_i(periph_trig_i),
		.wr_i(wr & srn_hit),
		.wr_idx_i(wb_adr_i[4:2]),
		.wr_dat_i(wb_dat_i[4:0]),
		.tos_o(target_cpu_select),
		.sre_o(request_enable_bit),
		.srr_o(request_pending_flag),
		.pend_o(pend),
		.win_o(win),
		.win_vld_o(win_vld)
	);

	// ======================================================================
	// Read mux; unmapped addresses read zero
	always_comb begin
		rd = 32'h0;
		if (srn_hit) begin
			rd[`CLPRG_SRN_TOS_BIT] = target_cpu_select[wb_adr_i[4:2]];
			rd[`CLPRG_SRN_SRE_BIT] = request_enable_bit[wb_adr_i[4:2]];
			rd[`CLPRG_SRN_SRR_BIT] = request_pending_flag[wb_adr_i[4:2]];
		end
		if (wb_adr_i == `CLPRG_OFS_MODE) begin
			rd[`CLPRG_NCPU-1:0] = s.idle;
			rd[`CLPRG_MODE_SLEEP_BIT] = s.sys_sleep;
			rd[`CLPRG_MODE_STBY_BIT] = s.sys_standby;
		end
		if (wb_adr_i == `CLPRG_OFS_ISTAT) begin
			rd[`CLPRG_EV_W-1:0] = s.stat;
		end
		if (wb_adr_i == `CLPRG_OFS_IMASK) begin
			rd[`CLPRG_EV_W-1:0] = s.mask;
		end
		for (int c = 0; c < `CLPRG_NCPU; c++) begin
			if (hit_cpu(wb_adr_i, `CLPRG_OFS_PMC0, c)) begin
				rd[1:0] = s.req[c];
			end
			if (hit_cpu(wb_adr_i, `CLPRG_OFS_LWR0, c)) begin
				rd[`CLPRG_IDX_W-1:0] = win[c];
				rd[`CLPRG_LWR_VLD_BIT] = win_vld[c];
			end
		end
	end

	// ======================================================================
	// Next-state logic
	always_comb begin
		n = s;
		ev = '0;
		n.ack = acc;
		n.dat = 32'h0;
		if (acc && !wb_we_i) begin
			n.dat = rd;
		end
		for (int c = 0; c < `CLPRG_NCPU; c++) begin
			n.wdt_prev[c] = wdt_bit15_i[c];
			unique case (s.st[c])
				CLPRG_CS_RUN: begin
					if (wr && hit_cpu(wb_adr_i, `CLPRG_OFS_PMC0, c)
							&& clprg_req_t'(wb_dat_i[1:0]) != CLPRG_REQ_RUN) begin
						if (pend[c]) begin
							// Field keeps run value
							ev[`CLPRG_EV_REF_LSB + c] = 1'b1;
						end else begin
							n.req[c] = clprg_req_t'(wb_dat_i[1:0]);
							n.st[c] = CLPRG_CS_APPLY;
							n.cnt[c] = `CLPRG_APPLY_RELOAD;
						end
					end
				end
				CLPRG_CS_APPLY: begin
					// CPU still executes; late interrupt aborts the entry
					if (pend[c]) begin
						n.req[c] = CLPRG_REQ_RUN;
						n.st[c] = CLPRG_CS_RUN;
						ev[`CLPRG_EV_REF_LSB + c] = 1'b1;
					end else if (s.cnt[c] == 3'h0) begin
						n.st[c] = CLPRG_CS_IDLE;
						n.idle[c] = 1'b1;
					end else begin
						n.cnt[c] = s.cnt[c] - 3'h1;
					end
				end
				CLPRG_CS_IDLE: begin
					// Stays idle until interrupt or watchdog bit rises
					if (pend[c] || (wdt_bit15_i[c] && !s.wdt_prev[c])) begin
						n.req[c] = CLPRG_REQ_RUN;
						n.st[c] = CLPRG_CS_RUN;
						n.idle[c] = 1'b0;
						ev[`CLPRG_EV_WAKE_LSB + c] = 1'b1;
					end
				end
				default: begin
					n.st[c] = CLPRG_CS_RUN;
					n.req[c] = CLPRG_REQ_RUN;
					n.idle[c] = 1'b0;
				end
			endcase
		end

		// System mode needs every CPU idle and nothing pending anywhere
		all_idle = &n.idle;
		sleep_req = 1'b0;
		stby_req = 1'b0;
		for (int c = 0; c < `CLPRG_NCPU; c++) begin
			if (n.idle[c] && is_low_req(n.req[c])) begin
				sleep_req = sleep_req | (n.req[c] == CLPRG_REQ_SLEEP);
				stby_req = stby_req | (n.req[c] == CLPRG_REQ_STANDBY);
			end
		end
		n.sys_standby = all_idle & ~(|pend) & stby_req;
		n.sys_sleep = all_idle & ~(|pend) & sleep_req & ~stby_req;
		ev[`CLPRG_EV_SYS_BIT] = (n.sys_sleep | n.sys_standby)
			& ~(s.sys_sleep | s.sys_standby);

		// Interrupt status: write one to clear, new event wins
		if (wr && wb_adr_i == `CLPRG_OFS_ISTAT) begin
			n.stat = s.stat & ~wb_dat_i[`CLPRG_EV_W-1:0];
		end
		n.stat = n.stat | ev;
		if (wr && wb_adr_i == `CLPRG_OFS_IMASK) begin
			n.mask = wb_dat_i[`CLPRG_EV_W-1:0];
		end
		n.irq = |(n.stat & n.mask);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s <= '0;
			s.mask <= `CLPRG_RST_MASK;
		end else begin
			s <= n;
		end
	end

	assign wb_dat_o = s.dat;
	assign wb_ack_o = s.ack;
	assign irq_o = s.irq;
	assign cpu_idle_o = s.idle;
	assign sys_sleep_o = s.sys_sleep;
	assign sys_standby_o = s.sys_standby;
endmodule
